/* File: design/slc_regs.svh */
// Register map constants for the serial link control register group.
// Assumes inclusion by bare name from design and bench files; definitions only.
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

// Register indices (byte address is four times the index)
`define SLC_IDX_LINK_ENABLE      12'h200
`define SLC_IDX_OUTPUT_MODE      12'h201
`define SLC_IDX_FRAMES_PER_MF    12'h202
`define SLC_IDX_SW_SYNC_REQ      12'h203
`define SLC_IDX_LINK_CONTROL     12'h204
`define SLC_IDX_CAL_ENABLE       12'h210
`define SLC_IDX_LINK_STATUS      12'h211

// Reset values
`define SLC_RST_LINK_ENABLE      8'h01
`define SLC_RST_OUTPUT_MODE      8'h02
`define SLC_RST_FRAMES_PER_MF    8'h1F
`define SLC_RST_SW_SYNC_REQ      8'h01
`define SLC_RST_LINK_CONTROL     8'h02
`define SLC_RST_CAL_ENABLE       8'h00

// Field positions
`define SLC_BIT_LINK_ENABLE      0
`define SLC_BIT_SW_SYNC_N        0
`define SLC_BIT_SCRAMBLER        0
`define SLC_BIT_SAMPLE_FORMAT    1
`define SLC_POS_SYNC_SEL_LO      2
`define SLC_POS_SYNC_SEL_HI      3
`define SLC_POS_MODE_HI          4

// Sync source codes
`define SLC_SYNC_SEL_PIN         2'h0
`define SLC_SYNC_SEL_TIMESTAMP   2'h1
`define SLC_SYNC_SEL_SOFTWARE    2'h2

// AXI responses
`define SLC_RESP_OKAY            2'h0
`define SLC_RESP_SLVERR          2'h2

`endif

/* File: design/slc_pkg.sv */
// Types for the serial link control register group.
// Assumes nothing beyond a SystemVerilog compiler.
package slc_pkg;
  typedef logic [7:0] slc_reg8_t;
  typedef enum logic [1:0] {
    SLC_WR_IDLE,
    SLC_WR_RESP
  } slc_wr_state_t;
endpackage

/* File: design/slc_sync2.sv */
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes core_clk_i is the only clock; reset is synchronous, active high.
`timescale 1ns/1ps
module slc_sync2 (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  input  wire logic rst_val_i,
  output logic      sync_o
);
  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta   <= rst_val_i;  // Idle level of the pin, so no false request
      sync_o <= rst_val_i;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

/* File: design/slc_link_ctrl.sv */
// Serial link control registers with an AXI4-Lite slave.
// Assumes one 20 MHz clock, synchronous active-high reset, async sync pins.
// Functional notes
// R1: Link enable is bit 0 of its register, resets to 1; 0 disables the link, 1 enables it.
// R2: Software clears link enable before changing other link configuration registers.
// R3: With link enable 0 the link logic is held in reset, serializers off, link clocks gated.
// R4: With the link disabled the LMFC counter is held in reset so SYSREF has no effect.
// R5: Software sets calibration enable before setting link enable.
// R6: Software clears link enable before clearing calibration enable.
// R7: Output mode is a 5-bit field, reset 00010, changed only with link and calibration off.
// R8: Frames-per-multiframe is a 5-bit field holding K-1, reset 31; software picks legal values.
// R9: Software writes frames-per-multiframe and link control only while link enable is 0.
// R10: A 0 in the software sync bit (bit 0, reset 1) requests sync like the sync pin.
// R11: The software sync bit can request sync whatever sync source is selected.
// R12: A stuck-low selected sync pin keeps the request asserted until source 2 is chosen.
// R13: Sync source bits 3:2, reset 0, pick the pin (0), timestamp input (1) or software (2).
// R14: Link control bit 1 picks offset binary (0) or two's complement (1), reset 1.
// R15: Link control bit 0 enables the scrambler, reset 0.
// R16: Reserved bits read and write, reset to zero, and do not affect the link.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "slc_regs.svh"
module slc_link_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // AXI4-Lite slave
  input  wire logic [15:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [15:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Sync sources, active low, asynchronous; timestamp receiver enable is active high
  input  wire logic        single_ended_sync_pin_n_i,
  input  wire logic        timestamp_diff_input_n_i,
  input  wire logic        timestamp_receiver_enable_i,
  // Link controls
  output logic             link_reset_o,
  output logic             serializer_power_down_o,
  output logic             link_clock_enable_o,
  output logic             lmfc_reset_o,
  output logic             sync_request_o,
  output logic [4:0]       output_mode_select_o,
  output logic [4:0]       frames_per_multiframe_minus_one_o,
  output logic             sample_format_o,
  output logic             scrambler_enable_o,
  output logic             calibration_enable_o
);
  slc_pkg::slc_reg8_t   link_enable_reg;
  slc_pkg::slc_reg8_t   output_mode_reg;
  slc_pkg::slc_reg8_t   frames_reg;
  slc_pkg::slc_reg8_t   sw_sync_reg;
  slc_pkg::slc_reg8_t   link_control_reg;
  slc_pkg::slc_reg8_t   cal_enable_reg;
  slc_pkg::slc_wr_state_t wr_state;
  logic [15:0]          aw_addr;
  logic                 aw_held;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 w_held;
  logic                 wr_go;
  logic                 pin_sync_n;
  logic                 ts_sync_n;
  logic                 next_sync_request;
  logic                 link_on;

  // Map a byte address to a register index; misaligned maps to no register
  function automatic logic [11:0] addr_to_idx(input logic [15:0] addr);
    addr_to_idx = (addr[1:0] == 2'h0) ? addr[13:2] : 12'hFFF;
  endfunction

  // Merge low byte lane into an 8-bit register
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge8 = strb[0] ? data[7:0] : old;
  endfunction

  function automatic logic is_mapped(input logic [11:0] idx);
    is_mapped = (idx >= `SLC_IDX_LINK_ENABLE && idx <= `SLC_IDX_LINK_CONTROL) ||
                idx == `SLC_IDX_CAL_ENABLE || idx == `SLC_IDX_LINK_STATUS;
  endfunction

  // Synchronise sync pins before any logic looks at them
  slc_sync2 u_pin_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    (single_ended_sync_pin_n_i),
    .rst_val_i  (1'b1),
    .sync_o     (pin_sync_n)
  );
  slc_sync2 u_ts_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    (timestamp_diff_input_n_i),
    .rst_val_i  (1'b1),
    .sync_o     (ts_sync_n)
  );

  assign wr_go   = aw_held && w_held && (wr_state == slc_pkg::SLC_WR_IDLE);
  assign link_on = link_enable_reg[`SLC_BIT_LINK_ENABLE];

  // Write address and data capture, either order
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 16'h0000;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      if (s_axi_awvalid_i && !aw_held && !s_axi_awready_o) begin
        s_axi_awready_o <= 1'b1;
        aw_held         <= 1'b1;
        aw_addr         <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_held && !s_axi_wready_o) begin
        s_axi_wready_o <= 1'b1;
        w_held         <= 1'b1;
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_state       <= slc_pkg::SLC_WR_IDLE;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `SLC_RESP_OKAY;
    end else begin
      case (wr_state)
        slc_pkg::SLC_WR_IDLE: begin
          if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= is_mapped(addr_to_idx(aw_addr)) &&
                              addr_to_idx(aw_addr) != `SLC_IDX_LINK_STATUS ?
                              `SLC_RESP_OKAY : `SLC_RESP_SLVERR;
            wr_state       <= slc_pkg::SLC_WR_RESP;
          end
        end
        slc_pkg::SLC_WR_RESP: begin
          if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            wr_state       <= slc_pkg::SLC_WR_IDLE;
          end
        end
        default: begin
          wr_state       <= slc_pkg::SLC_WR_IDLE;
          s_axi_bvalid_o <= 1'b0;
        end
      endcase
    end
  end

  // Register storage; reserved bits are plain storage with no effect [R16]
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      link_enable_reg  <= `SLC_RST_LINK_ENABLE;  // [R1]
      output_mode_reg  <= `SLC_RST_OUTPUT_MODE;  // [R7]
      frames_reg       <= `SLC_RST_FRAMES_PER_MF; // [R8]
      sw_sync_reg      <= `SLC_RST_SW_SYNC_REQ;  // [R10]
      link_control_reg <= `SLC_RST_LINK_CONTROL; // [R13] [R14] [R15]
      cal_enable_reg   <= `SLC_RST_CAL_ENABLE;
    end else if (wr_go) begin
      case (addr_to_idx(aw_addr))
        `SLC_IDX_LINK_ENABLE:   link_enable_reg  <= merge8(link_enable_reg, w_data, w_strb);
        `SLC_IDX_OUTPUT_MODE:   output_mode_reg  <= merge8(output_mode_reg, w_data, w_strb);
        `SLC_IDX_FRAMES_PER_MF: frames_reg       <= merge8(frames_reg, w_data, w_strb);
        `SLC_IDX_SW_SYNC_REQ:   sw_sync_reg      <= merge8(sw_sync_reg, w_data, w_strb);
        `SLC_IDX_LINK_CONTROL:  link_control_reg <= merge8(link_control_reg, w_data, w_strb);
        `SLC_IDX_CAL_ENABLE:    cal_enable_reg   <= merge8(cal_enable_reg, w_data, w_strb);
        default: begin
        end
      endcase
    end
  end

  // Read channel, data valid in the same cycle that the address is taken
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `SLC_RESP_OKAY;
    end else begin
      s_axi_arready_o <= 1'b0;
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
      if (s_axi_arvalid_i && !s_axi_rvalid_o && !s_axi_arready_o) begin
        s_axi_arready_o <= 1'b1;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rresp_o   <= is_mapped(addr_to_idx(s_axi_araddr_i)) ?
                           `SLC_RESP_OKAY : `SLC_RESP_SLVERR;
        case (addr_to_idx(s_axi_araddr_i))
          `SLC_IDX_LINK_ENABLE:   s_axi_rdata_o <= {24'h000000, link_enable_reg};
          `SLC_IDX_OUTPUT_MODE:   s_axi_rdata_o <= {24'h000000, output_mode_reg};
          `SLC_IDX_FRAMES_PER_MF: s_axi_rdata_o <= {24'h000000, frames_reg};
          `SLC_IDX_SW_SYNC_REQ:   s_axi_rdata_o <= {24'h000000, sw_sync_reg};
          `SLC_IDX_LINK_CONTROL:  s_axi_rdata_o <= {24'h000000, link_control_reg};
          `SLC_IDX_CAL_ENABLE:    s_axi_rdata_o <= {24'h000000, cal_enable_reg};
          `SLC_IDX_LINK_STATUS:   s_axi_rdata_o <= {28'h0000000, link_reset_o,
                                                   lmfc_reset_o, sync_request_o, link_on};
          default:                s_axi_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sync request: software bit always counts, pins only by source select
  always_comb begin
    next_sync_request = !sw_sync_reg[`SLC_BIT_SW_SYNC_N];  // [R10] [R11]
    case (link_control_reg[`SLC_POS_SYNC_SEL_HI:`SLC_POS_SYNC_SEL_LO])  // [R13]
      `SLC_SYNC_SEL_PIN:       next_sync_request = next_sync_request || !pin_sync_n;  // [R12]
      `SLC_SYNC_SEL_TIMESTAMP: next_sync_request = next_sync_request ||
                                 (timestamp_receiver_enable_i && !ts_sync_n);  // [R12]
      default:                 next_sync_request = next_sync_request;
    endcase
  end

  // Link side outputs, all registered
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      link_reset_o                      <= 1'b0;
      serializer_power_down_o           <= 1'b0;
      link_clock_enable_o               <= 1'b1;
      lmfc_reset_o                      <= 1'b0;
      sync_request_o                    <= 1'b0;
      output_mode_select_o              <= 5'h02;
      frames_per_multiframe_minus_one_o <= 5'h1F;
      sample_format_o                   <= 1'b1;
      scrambler_enable_o                <= 1'b0;
      calibration_enable_o              <= 1'b0;
    end else begin
      link_reset_o                      <= !link_on;  // [R3]
      serializer_power_down_o           <= !link_on;  // [R3]
      link_clock_enable_o               <= link_on;   // [R3]
      lmfc_reset_o                      <= !link_on;  // [R4]
      sync_request_o                    <= next_sync_request;
      output_mode_select_o              <= output_mode_reg[`SLC_POS_MODE_HI:0];  // [R7]
      frames_per_multiframe_minus_one_o <= frames_reg[`SLC_POS_MODE_HI:0];       // [R8]
      sample_format_o                   <= link_control_reg[`SLC_BIT_SAMPLE_FORMAT];  // [R14]
      scrambler_enable_o                <= link_control_reg[`SLC_BIT_SCRAMBLER];      // [R15]
      calibration_enable_o              <= cal_enable_reg[0];
    end
  end

  // Link follows its enable one edge later
  AST_LINK_RESET_FOLLOWS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    link_reset_o == !$past(link_on)) else $error("link reset mismatch"); // [R3]
  AST_POWER_AND_CLOCK: assert property (@(posedge core_clk_i) disable iff (reset_i)
    serializer_power_down_o == !link_clock_enable_o) else $error("power/clock mismatch"); // [R3]
  AST_LMFC_HELD: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !link_on |=> lmfc_reset_o) else $error("lmfc not held"); // [R4]
  AST_SW_SYNC: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !sw_sync_reg[0] |=> sync_request_o) else $error("sw sync ignored"); // [R11]
  AST_SOFT_SOURCE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (sw_sync_reg[0] && link_control_reg[3:2] == 2'h2) |=> !sync_request_o)
    else $error("sync not released"); // [R12]
  AST_PIN_SYNC: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (link_control_reg[3:2] == 2'h0 && !pin_sync_n) |=> sync_request_o)
    else $error("pin sync ignored"); // [R13]
  AST_FORMAT: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 sample_format_o == $past(link_control_reg[1])) else $error("format mismatch"); // [R14]
  AST_SCRAMBLER: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 scrambler_enable_o == $past(link_control_reg[0])) else $error("scrambler mismatch"); // [R15]
  AST_ENABLE_WRITE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wr_go && addr_to_idx(aw_addr) == 12'h200 && w_strb[0]) |=> link_on == $past(w_data[0]))
    else $error("enable write lost"); // [R1]
  AST_MODE_FIELD: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 output_mode_select_o == $past(output_mode_reg[4:0])) else $error("mode mismatch"); // [R7]
  AST_FRAMES_FIELD: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R8]
    ##1 frames_per_multiframe_minus_one_o == $past(frames_reg[4:0]))
    else $error("frames mismatch");
  // Timestamp source counts only with its receiver enabled
  AST_TS_GATED: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R13]
    (link_control_reg[3:2] == 2'h1 && !timestamp_receiver_enable_i && sw_sync_reg[0])
    |=> !sync_request_o) else $error("timestamp sync not gated");

  COV_LINK_OFF: cover property (@(posedge core_clk_i) link_on ##1 !link_on);
  COV_SW_SYNC: cover property (@(posedge core_clk_i) !sw_sync_reg[0] ##1 sync_request_o);
  COV_READ: cover property (@(posedge core_clk_i) s_axi_rvalid_o && s_axi_rready_i);
  COV_TS_SYNC: cover property (@(posedge core_clk_i)
    (link_control_reg[3:2] == 2'h1 && !ts_sync_n) ##1 sync_request_o);
endmodule

/* File: verification/slc_rx_model.sv */
// Far-end receiver model: drives the active-low sync request lines.
// Assumes the bench commands requests; the idle line sits high.
`timescale 1ns/1ps
module slc_rx_model (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic want_sync_i,
  input  wire logic use_ts_i,
  input  wire logic slow_i,
  output logic      sync_pin_n_o,
  output logic      ts_diff_n_o
);
  logic [2:0] dly;
  logic       req;
  // Delay line so the receiver can answer promptly or slowly
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dly <= 3'h0;
    end else begin
      dly <= {dly[1:0], want_sync_i};
    end
  end
  // Request goes out low on the chosen line only
  assign req          = slow_i ? dly[2] : dly[0];
  assign sync_pin_n_o = !(req && !use_ts_i);
  assign ts_diff_n_o  = !(req && use_ts_i);
endmodule

/* File: verification/slc_link_ctrl_tb.sv */
// Self-checking bench for the link control registers over AXI4-Lite.
// Assumes the receiver model on the sync lines and a 20 MHz clock.
`timescale 1ns/1ps
`include "slc_regs.svh"
module slc_link_ctrl_tb;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        pin_n, ts_n, ts_en, want, use_ts, slow;
  logic        lrst, pd, cken, lmfc, sreq, fmt, scrambler_enable, cal;
  logic [4:0]  mode, kf;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          fails, tests_run;

  slc_link_ctrl dut (
    .core_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .single_ended_sync_pin_n_i(pin_n), .timestamp_diff_input_n_i(ts_n),
    .timestamp_receiver_enable_i(ts_en), .link_reset_o(lrst),
    .serializer_power_down_o(pd), .link_clock_enable_o(cken), .lmfc_reset_o(lmfc),
    .sync_request_o(sreq), .output_mode_select_o(mode),
    .frames_per_multiframe_minus_one_o(kf), .sample_format_o(fmt),
    .scrambler_enable_o(scrambler_enable), .calibration_enable_o(cal)
  );

  slc_rx_model rx (
    .core_clk_i(clk), .reset_i(rst), .want_sync_i(want), .use_ts_i(use_ts),
    .slow_i(slow), .sync_pin_n_o(pin_n), .ts_diff_n_o(ts_n)
  );

  function automatic logic [15:0] ba(input logic [11:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    exp_b.push_back(er);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Wait for the answer; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    exp_r.push_back({er, 24'h000000, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic link_chk(input logic en);
    check("link", {30'h0, lrst, pd, cken, lmfc}, {30'h0, !en, !en, en, !en});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Response monitor takes the oldest note at each handshake
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) check("bresp", {32'h0, bresp}, {32'h0, exp_b.pop_front()});
    if (rvalid === 1'b1 && rready === 1'b1) check("rdata", {rresp, rdata}, exp_r.pop_front());
  end

  // Clock at 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  // Main sequence
  initial begin
    logic [7:0] m, k, c;
    int         i;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = '0;
    {ts_en, want, use_ts, slow} = 4'h0;
    void'($urandom(5));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Reset values of all writable registers and outputs
    rd(ba(`SLC_IDX_LINK_ENABLE), `SLC_RST_LINK_ENABLE, `SLC_RESP_OKAY);
    rd(ba(`SLC_IDX_OUTPUT_MODE), `SLC_RST_OUTPUT_MODE, `SLC_RESP_OKAY);
    rd(ba(`SLC_IDX_FRAMES_PER_MF), `SLC_RST_FRAMES_PER_MF, `SLC_RESP_OKAY);
    rd(ba(`SLC_IDX_SW_SYNC_REQ), `SLC_RST_SW_SYNC_REQ, `SLC_RESP_OKAY);
    rd(ba(`SLC_IDX_LINK_CONTROL), `SLC_RST_LINK_CONTROL, `SLC_RESP_OKAY);
    rd(ba(`SLC_IDX_CAL_ENABLE), `SLC_RST_CAL_ENABLE, `SLC_RESP_OKAY);
    link_chk(1'b1);
    check("fields", {21'h0, mode, kf, fmt, scrambler_enable, cal}, {21'h0, 5'h02, 5'h1F, 3'b100});
    check("sync", {33'h0, sreq}, 34'h0);
    // Link off first, calibration off, then program with reserved bits
    wr(ba(`SLC_IDX_LINK_ENABLE), 8'h00, `SLC_RESP_OKAY);
    wr(ba(`SLC_IDX_CAL_ENABLE), 8'h00, `SLC_RESP_OKAY);
    link_chk(1'b0);
    for (i = 0; i < 4; i++) begin
      m = 8'($urandom());
      k = 8'($urandom());
      c = {4'($urandom()), 2'h0, 2'($urandom())};
      wr(ba(`SLC_IDX_OUTPUT_MODE), m, `SLC_RESP_OKAY);
      wr(ba(`SLC_IDX_FRAMES_PER_MF), k, `SLC_RESP_OKAY);
      wr(ba(`SLC_IDX_LINK_CONTROL), c, `SLC_RESP_OKAY);
      rd(ba(`SLC_IDX_OUTPUT_MODE), m, `SLC_RESP_OKAY);
      rd(ba(`SLC_IDX_FRAMES_PER_MF), k, `SLC_RESP_OKAY);
      rd(ba(`SLC_IDX_LINK_CONTROL), c, `SLC_RESP_OKAY);
      check("fields", {21'h0, mode, kf, fmt, scrambler_enable, cal}, {21'h0, m[4:0], k[4:0], c[1:0], 1'b0});
    end
    // Each sync source code: receiver request on pin or timestamp line, then software request
    for (i = 0; i < 4; i++) begin
      wr(ba(`SLC_IDX_LINK_CONTROL), {4'h0, 2'(i), 2'b10}, `SLC_RESP_OKAY);
      use_ts <= (i == 1);
      ts_en  <= 1'b1;
      slow   <= (i == 1);
      want   <= 1'b1;
      repeat (10) @(posedge clk);
      check("sync", {33'h0, sreq}, {33'h0, i < 2});
      want <= 1'b0;
      repeat (10) @(posedge clk);
      check("sync", {33'h0, sreq}, 34'h0);
      wr(ba(`SLC_IDX_SW_SYNC_REQ), 8'h00, `SLC_RESP_OKAY);
      check("sync", {33'h0, sreq}, 34'h1);
      wr(ba(`SLC_IDX_SW_SYNC_REQ), 8'h01, `SLC_RESP_OKAY);
      check("sync", {33'h0, sreq}, 34'h0);
    end
    // Timestamp source with its receiver off raises nothing
    wr(ba(`SLC_IDX_LINK_CONTROL), 8'h06, `SLC_RESP_OKAY);
    use_ts <= 1'b1;
    ts_en  <= 1'b0;
    want   <= 1'b1;
    repeat (10) @(posedge clk);
    check("sync", {33'h0, sreq}, 34'h0);
    want <= 1'b0;
    repeat (10) @(posedge clk);
    // Bring the link up in order, then down in order
    wr(ba(`SLC_IDX_CAL_ENABLE), 8'h01, `SLC_RESP_OKAY);
    wr(ba(`SLC_IDX_LINK_ENABLE), 8'h01, `SLC_RESP_OKAY);
    link_chk(1'b1);
    check("cal", {33'h0, cal}, 34'h1);
    rd(ba(`SLC_IDX_LINK_STATUS), 8'h01, `SLC_RESP_OKAY);
    wr(ba(`SLC_IDX_LINK_ENABLE), 8'h00, `SLC_RESP_OKAY);
    wr(ba(`SLC_IDX_CAL_ENABLE), 8'h00, `SLC_RESP_OKAY);
    link_chk(1'b0);
    // Refused writes leave the registers alone
    wr(16'h0FFC, 8'hFF, `SLC_RESP_SLVERR);
    wr(ba(`SLC_IDX_LINK_ENABLE) + 16'h0002, 8'hFF, `SLC_RESP_SLVERR);
    wr(ba(`SLC_IDX_LINK_STATUS), 8'hFF, `SLC_RESP_SLVERR);
    rd(ba(`SLC_IDX_LINK_ENABLE), 8'h00, `SLC_RESP_OKAY);
    link_chk(1'b0);
    rd(ba(`SLC_IDX_LINK_STATUS), 8'h0C, `SLC_RESP_OKAY);
    rd(16'h0FFC, 8'h00, `SLC_RESP_SLVERR);
    wrap_up();
  end
endmodule
